// ---- rtl/cfg_lock_consts.vh ----
// Purpose: constants for the configuration and port lock register bank
// Assumes: 16-bit register addresses as seen by the serial port logic
// Notes: definitions only
`ifndef CFG_LOCK_CONSTS_VH
`define CFG_LOCK_CONSTS_VH
// ---------------------------------------------
// addresses
// ---------------------------------------------
`define ADDR_LP_OC_LEVEL 16'hec00
`define ADDR_CONFIG_TWO 16'hec01
`define ADDR_HARM_CFG 16'he601
// ---------------------------------------------
// fields and resets
// ---------------------------------------------
`define HTB_LSB 8
`define HTB_MSB 9
`define LP_OVERCURRENT_THRESHOLD_LSB 0
`define LP_OVERCURRENT_THRESHOLD_MSB 2
`define LP_MEASURE_LINE_COUNT_LSB 3
`define LP_MEASURE_LINE_COUNT_MSB 7
`define EXTREF_BIT 0
`define LOCK_BIT 1
`define LP_OVERCURRENT_THRESHOLD_RESET 3'h7
`define LP_MEASURE_LINE_COUNT_RESET 5'h00
`define HTB_RESET 2'h0
`define TOGGLES_FOR_SPI 2'h3
// ---------------------------------------------
// timing
// ---------------------------------------------
`define LINE_PERIOD_NS 20000000
`define CLK_PERIOD_NS 5
`define LINE_CYCLES (`LINE_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// ---- rtl/line_period_timer.v ----
// Purpose: measurement period timer, (count+1) line periods of 1/50 s
// Assumes: 200 MHz clock
// Notes: emits one pulse at end of each period
`timescale 1ns/1ps
`include "cfg_lock_consts.vh"
module line_period_timer #(
    parameter LINE_CYCLES = `LINE_CYCLES
) (
    input wire clk,
    input wire reset_n,
    input wire [4:0] line_count,
    output reg period_done
);
    reg [31:0] tick;
    reg [4:0] lines;
    wire line_end = (tick == LINE_CYCLES - 1);
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick <= 32'h0;
            lines <= 5'h00;
            period_done <= 1'b0;
        end else begin
            period_done <= 1'b0;
            if (line_end) begin
                tick <= 32'h0;
                // a shorter count taking effect mid-period still ends cleanly
                if (lines >= line_count) begin
                    lines <= 5'h00;
                    period_done <= 1'b1;
                end else begin
                    lines <= lines + 5'h01;
                end
            end else begin
                tick <= tick + 32'h1;
            end
        end
    end
endmodule // line_period_timer

// ---- rtl/config_and_port_lock_regs.v ----
// Purpose: low-power overcurrent, config_two and harmonic time-base registers
// Assumes: serial port front end presents 16-bit word accesses in I_CLK domain
// Notes: port_select_pin sampled synchronously; toggles counted on edges
//
// Function
// - time-base code 00 selects phase A
// - 01 B, 10 C, 11 acts as C
// - threshold is full scale times field/8
// - period lasts (line field+1)/50 seconds
// - reference select: 0 internal, 1 external
// - unlocked: three pin toggles activate SPI
// - I2C locked: pin toggles ignored until reset
// - SPI active: any config_two write locks
// - lock survives every power mode change
// - reserved bits control nothing, reset zero
`timescale 1ns/1ps
`include "cfg_lock_consts.vh"
module config_and_port_lock_regs #(
    parameter LINE_CYCLES = `LINE_CYCLES
) (
    input wire I_CLK,
    input wire I_RESET_N,
    input wire [15:0] I_ADDR,
    input wire I_WR,
    input wire I_RD,
    input wire [15:0] I_WDATA,
    input wire I_PORT_SELECT_PIN,
    input wire [1:0] I_POWER_MODE,
    input wire [7:0] I_FULL_SCALE,
    output reg [15:0] O_RDATA,
    output wire O_SPI_ACTIVE,
    output wire O_PORT_LOCKED,
    output wire [1:0] O_TIMEBASE_PHASE,
    output wire [7:0] O_LP_THRESHOLD,
    output wire O_LP_PERIOD_DONE,
    output wire O_EXTERNAL_REFERENCE
);
    // ---------------------------------------------
    // storage
    // ---------------------------------------------
    reg [2:0] lp_overcurrent_threshold;
    reg [4:0] lp_measure_line_count;
    reg external_reference_select;
    reg port_lock;
    reg spi_active;
    reg [1:0] harmonic_timebase_phase_sel;
    reg [1:0] toggles;
    reg pin_last;
    reg [10:0] thr_product;

    function [1:0] phase_of;
        input [1:0] code;
        begin
            phase_of = (code == 2'h3) ? 2'h2 : code;
        end
    endfunction

    function addr_hit;
        input [15:0] addr;
        input [15:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // ---------------------------------------------
    // decode
    // ---------------------------------------------
    wire wr_lvl = I_WR && addr_hit(I_ADDR, `ADDR_LP_OC_LEVEL);
    wire wr_cfg = I_WR && addr_hit(I_ADDR, `ADDR_CONFIG_TWO);
    wire wr_htb = I_WR && addr_hit(I_ADDR, `ADDR_HARM_CFG);
    wire pin_edge = (I_PORT_SELECT_PIN != pin_last);

    // ---------------------------------------------
    // register writes
    // ---------------------------------------------
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            lp_overcurrent_threshold <= `LP_OVERCURRENT_THRESHOLD_RESET;
        end else if (wr_lvl) begin
            lp_overcurrent_threshold <= I_WDATA[`LP_OVERCURRENT_THRESHOLD_MSB:`LP_OVERCURRENT_THRESHOLD_LSB];
        end
    end

    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            lp_measure_line_count <= `LP_MEASURE_LINE_COUNT_RESET;
        end else if (wr_lvl) begin
            lp_measure_line_count <= I_WDATA[`LP_MEASURE_LINE_COUNT_MSB:`LP_MEASURE_LINE_COUNT_LSB];
        end
    end

    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            external_reference_select <= 1'b0;
        end else if (wr_cfg) begin
            external_reference_select <= I_WDATA[`EXTREF_BIT];
        end
    end

    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            harmonic_timebase_phase_sel <= `HTB_RESET;
        end else if (wr_htb) begin
            // upper bits dropped, only the selector is stored
            harmonic_timebase_phase_sel <= I_WDATA[`HTB_MSB:`HTB_LSB];
        end
    end

    // ---------------------------------------------
    // serial port selection, next values
    // ---------------------------------------------
    // power_mode deliberately not an input to this logic: lock must survive it
    reg next_port_lock;
    reg next_spi_active;
    reg [1:0] next_toggles;

    always @* begin
        next_spi_active = spi_active;
        next_toggles = toggles;
        if (!port_lock && !spi_active && pin_edge) begin
            if (toggles == `TOGGLES_FOR_SPI - 2'h1) begin
                next_spi_active = 1'b1;
                next_toggles = 2'h0;
            end else begin
                next_toggles = toggles + 2'h1;
            end
        end
    end

    always @* begin
        next_port_lock = port_lock;
        if (wr_cfg && !port_lock) begin
            if (spi_active) begin
                next_port_lock = 1'b1;
            end else begin
                next_port_lock = I_WDATA[`LOCK_BIT];
            end
        end
        // no path clears port_lock except reset
    end

    // ---------------------------------------------
    // serial port selection, state
    // ---------------------------------------------
    // pin idles high, so the edge detector starts there to avoid a false toggle
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pin_last <= 1'b1;
        end else begin
            pin_last <= I_PORT_SELECT_PIN;
        end
    end

    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            spi_active <= 1'b0;
            toggles <= 2'h0;
        end else begin
            spi_active <= next_spi_active;
            toggles <= next_toggles;
        end
    end

    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            port_lock <= 1'b0;
        end else begin
            port_lock <= next_port_lock;
        end
    end

    // ---------------------------------------------
    // read back
    // ---------------------------------------------
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_RDATA <= 16'h0000;
        end else if (I_RD) begin
            case (I_ADDR)
                `ADDR_LP_OC_LEVEL: O_RDATA <= {8'h00, lp_measure_line_count, lp_overcurrent_threshold};
                `ADDR_CONFIG_TWO: O_RDATA <= {14'h0000, port_lock, external_reference_select};
                `ADDR_HARM_CFG: O_RDATA <= {6'h00, harmonic_timebase_phase_sel, 8'h00};
                default: O_RDATA <= 16'h0000;
            endcase
        end
    end

    // ---------------------------------------------
    // threshold and period
    // ---------------------------------------------
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            thr_product <= 11'h000;
        end else begin
            thr_product <= I_FULL_SCALE * lp_overcurrent_threshold;
        end
    end
    assign O_LP_THRESHOLD = thr_product[10:3];

    line_period_timer #(
        .LINE_CYCLES(LINE_CYCLES)
    ) u_timer (
        .clk(I_CLK),
        .reset_n(I_RESET_N),
        .line_count(lp_measure_line_count),
        .period_done(O_LP_PERIOD_DONE)
    );

    assign O_SPI_ACTIVE = spi_active;
    assign O_PORT_LOCKED = port_lock;
    assign O_TIMEBASE_PHASE = phase_of(harmonic_timebase_phase_sel);
    assign O_EXTERNAL_REFERENCE = external_reference_select;
endmodule // config_and_port_lock_regs

// ---- tb/host_model.sv ----
// Purpose: host side model, register strobes and port pin
// Assumes: device takes requests on rising clk
// Notes: released address and data lines show inverted values, strobes go low
`timescale 1ns/1ps
module host_model (
    input wire clk,
    output logic wr,
    output logic rd,
    output logic pin,
    output logic [15:0] addr,
    output logic [15:0] wdata
);
    // --------------------------------
    // bus and pin tasks
    // --------------------------------
    initial begin
        {addr, wdata, wr, rd, pin} = {32'h0, 3'b001};
    end
    task access(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        #1 {addr, wdata, wr, rd} = {a, d, w, !w};
        @(posedge clk);
        #1 {addr, wdata, wr, rd} = {~a, ~d, 2'b00};
    endtask
    // idle edge between changes, pin idles high
    task toggle(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 pin = ~pin;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        #1;
    endtask
endmodule // host_model

// ---- tb/cfg_lock_properties.sv ----
// Purpose: port checks of the config regs
// Assumes: single clock domain
// Notes: bound to the top module
`timescale 1ns/1ps
module cfg_lock_properties #(parameter LINE_CYCLES = 10) (
    input wire I_CLK, input wire I_RESET_N, input wire [15:0] I_ADDR,
    input wire I_WR, input wire I_RD, input wire [15:0] I_WDATA, input wire [15:0] O_RDATA,
    input wire O_SPI_ACTIVE, input wire O_PORT_LOCKED, input wire [1:0] O_TIMEBASE_PHASE,
    input wire O_LP_PERIOD_DONE, input wire O_EXTERNAL_REFERENCE
);
    // --------------------------------
    // properties
    // --------------------------------
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    wire w1 = I_WR && I_ADDR == 16'he601;
    wire w2 = I_WR && I_ADDR == 16'hec01;
    AST_PHASE: assert property (w1 |=> O_TIMEBASE_PHASE == ($past(I_WDATA[9:8]) == 2'h3 ? 2'h2 : $past(I_WDATA[9:8])))
        else $error("bad phase");
    AST_EXTREF: assert property (w2 |=> O_EXTERNAL_REFERENCE == $past(I_WDATA[0]))
        else $error("bad reference select");
    AST_I2C_LOCK: assert property (w2 && !O_SPI_ACTIVE && I_WDATA[1] |=> O_PORT_LOCKED)
        else $error("no i2c lock");
    AST_SPI_LOCK: assert property (w2 && O_SPI_ACTIVE |=> O_PORT_LOCKED)
        else $error("no spi lock");
    AST_LOCK_KEEP: assert property (O_PORT_LOCKED |=> O_PORT_LOCKED [*2])
        else $error("lock lost");
    AST_NO_SPI: assert property (O_PORT_LOCKED && !O_SPI_ACTIVE |=> !O_SPI_ACTIVE)
        else $error("spi after i2c lock");
    AST_SPI_KEEP: assert property (O_SPI_ACTIVE |=> O_SPI_ACTIVE)
        else $error("left spi");
    AST_SPI_CAUSE: assert property ($rose(O_SPI_ACTIVE) |-> !$past(O_PORT_LOCKED))
        else $error("spi while locked");
    AST_RSVD: assert property (I_RD && I_ADDR == 16'hec01 |=> O_RDATA[15:2] == 14'h0)
        else $error("reserved bits set");
    AST_PULSE: assert property (O_LP_PERIOD_DONE |=> !O_LP_PERIOD_DONE)
        else $error("long period pulse");
endmodule // cfg_lock_properties
bind config_and_port_lock_regs cfg_lock_properties #(.LINE_CYCLES(LINE_CYCLES)) i_props (.I_CLK, .I_RESET_N,
    .I_ADDR, .I_WR, .I_RD, .I_WDATA, .O_RDATA, .O_SPI_ACTIVE, .O_PORT_LOCKED, .O_TIMEBASE_PHASE,
    .O_LP_PERIOD_DONE, .O_EXTERNAL_REFERENCE);

// ---- tb/config_and_port_lock_regs_tb.sv ----
// Purpose: self-checking bench of the config regs
// Assumes: host model drives strobes and pin
// Notes: short line period keeps the run brief
`timescale 1ns/1ps
`define CHK(v, e) begin comparisons++; if ((v) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: %h vs %h", $time, v, e); end end
module config_and_port_lock_regs_tb;
    // --------------------------------
    // bench
    // --------------------------------
    logic clk = 0, reset_n = 0;
    logic [1:0] power_mode = 2'h0;
    wire [15:0] addr, wdata, rdata;
    wire wr, rd, pin, spi, locked, done, extref;
    wire [1:0] phase;
    wire [7:0] thr;
    int miscompares = 0, comparisons = 0, c;
    logic [49:0] rows [6] = '{{16'he601, 16'h0000, 16'h0000, 2'h0}, {16'he601, 16'h0100, 16'h0100, 2'h1},
        {16'he601, 16'h0200, 16'h0200, 2'h2}, {16'he601, 16'hfb00, 16'h0300, 2'h2},
        {16'hec00, 16'hff3d, 16'h003d, 2'h2}, {16'hec01, 16'h00fd, 16'h0001, 2'h2}};
    always #2.5 clk = ~clk;
    host_model h (.clk(clk), .wr(wr), .rd(rd), .pin(pin), .addr(addr), .wdata(wdata));
    config_and_port_lock_regs #(.LINE_CYCLES(10)) i_dut (.I_CLK(clk), .I_RESET_N(reset_n), .I_ADDR(addr),
        .I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .I_PORT_SELECT_PIN(pin), .I_POWER_MODE(power_mode),
        .I_FULL_SCALE(8'h80), .O_RDATA(rdata), .O_SPI_ACTIVE(spi), .O_PORT_LOCKED(locked),
        .O_TIMEBASE_PHASE(phase), .O_LP_THRESHOLD(thr), .O_LP_PERIOD_DONE(done), .O_EXTERNAL_REFERENCE(extref));
    task complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task pulse;
        c = 0;
        do begin
            @(posedge clk);
            #1 c++;
        end while (done !== 1'b1 && c < 500);
    endtask
    task reset_dut;
        reset_n = 0;
        repeat (16) @(posedge clk);
        #1 reset_n = 1;
    endtask
    // mode changes must not touch the lock
    task modes;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            #1 power_mode = m[1:0];
        end
    endtask
    initial begin
        #200000 miscompares++;
        complete_run;
    end
    initial begin
        reset_dut;
        h.access(0, 16'hec00, 16'h0);
        `CHK(rdata, 16'h0007)
        `CHK(thr, 8'h70)
        `CHK({extref, locked, phase}, 4'h0)
        for (int i = 0; i < 6; i++) begin
            h.access(1, rows[i][49:34], rows[i][33:18]);
            h.access(0, rows[i][49:34], 16'h0);
            `CHK(rdata, rows[i][17:2])
            `CHK(phase, rows[i][1:0])
        end
        `CHK({extref, locked}, 2'b10)
        `CHK(thr, 8'h50)
        pulse;
        pulse;
        pulse;
        `CHK(c, 80)
        $display("register test done");
        h.access(1, 16'hec01, 16'h0002);
        `CHK(locked, 1'b1)
        h.toggle(4);
        h.access(1, 16'hec01, 16'h0000);
        `CHK({spi, locked}, 2'b01)
        modes;
        `CHK(locked, 1'b1)
        $display("i2c lock test done");
        reset_dut;
        h.toggle(3);
        `CHK({spi, locked}, 2'b10)
        h.access(1, 16'hec01, 16'h0000);
        modes;
        `CHK({spi, locked}, 2'b11)
        $display("spi lock test done");
        complete_run;
    end
endmodule // config_and_port_lock_regs_tb
